/* File: hdl/sabf_pkg.sv */
// Package: constants and types for the sideband fanout controller
package sabf_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int WD_TIME_MS     = 20;
    localparam int WD_CYCLES      = (WD_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int GAP_TIME_NS    = 1000;
    localparam int GAP_CYCLES     = GAP_TIME_NS / CLK_PERIOD_NS;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CMD_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] TXREQ_OFS  = 8'h0c;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTRL_SWITCH_BIT   = 0;
    localparam int CTRL_SNOOP_BIT    = 1;
    localparam int CTRL_SNBRAKE_BIT  = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int ST_LIVE_POS = 8;
    localparam int ST_WD_BIT    = 16;
    localparam int ST_SNOOP_BIT = 17;
    localparam int ST_BRAKE_BIT = 18;
    localparam int ST_ABORT_BIT = 19;
    localparam int ST_RXERR_BIT = 20;
    localparam int ST_RESP_BIT  = 21;
    // ----------------------------------------
    // Commands and types
    // ----------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_TARGET = 3'h1,
        CMD_SELECT = 3'h2,
        CMD_BRAKE  = 3'h3,
        CMD_OTHER  = 3'h4
    } sabf_cmd_code_t;
    typedef struct packed {
        sabf_cmd_code_t code;
        logic [7:0]     mask;
    } sabf_cmd_t;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_CHECK = 3'b010,
        TX_HALT  = 3'b100
    } sabf_tx_state_t;
endpackage : sabf_pkg

/* File: hdl/sabf_fanout.sv */
// Fanout controller with switch-mode brake broadcast, abort check and watchdog
module sabf_fanout #(
    parameter int NUM_SEG  = 8,
    parameter int WD_LIMIT = sabf_pkg::WD_CYCLES
) (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // AHB-Lite slave
    input  wire logic               hsel_in,
    input  wire logic [7:0]         haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [31:0]        hwdata_in,
    input  wire logic               hready_in,
    output logic      [31:0]        hrdata_out,
    output logic                    hreadyout_out,
    output logic                    hresp_out,
    // Upstream wire and frame status
    input  wire logic               up_wire_in,
    output logic                    up_wire_out,
    output logic                    up_wire_oe_out,
    input  wire logic               other_target_in,
    input  wire logic               rx_parity_err_in,
    input  wire logic               rx_frame_err_in,
    output logic                    frame_start_out,
    output logic                    target_cmd_out,
    output logic                    power_reduce_command_out,
    // Downstream segments
    input  wire logic [NUM_SEG-1:0] seg_wire_in,
    output logic      [NUM_SEG-1:0] seg_wire_out,
    output logic      [NUM_SEG-1:0] seg_wire_oe_out
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (NUM_SEG < 2 || NUM_SEG > 8) begin : g_bad_seg
        $error("NUM_SEG must be 2 to 8");
    end
    if (WD_LIMIT < 1) begin : g_bad_wd
        $error("WD_LIMIT must be positive");
    end

    localparam logic [NUM_SEG-1:0] SEL_MUX_DEF = '0;
    localparam logic [NUM_SEG-1:0] SEL_SW_DEF  = NUM_SEG'(1);

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic [2:0]           ctrl_reg;
    logic                 wr_pend_reg;
    logic [7:0]           wr_addr_reg;
    logic                 rd_status;
    logic                 wr_cmd;
    logic                 wr_tx;
    logic                 switch_m;
    logic                 snoop;
    logic [NUM_SEG-1:0]   sel_reg;
    logic [NUM_SEG-1:0]   wd_chan_reg;
    logic                 wd_reason_reg;
    logic                 brake_reg;
    logic                 bcast_all_reg;
    logic                 abort_seen_reg;
    logic                 rx_abort_reg;
    logic                 respond_reg;
    logic [31:0]          status;
    sabf_pkg::sabf_cmd_t  cmd;
    sabf_pkg::sabf_tx_state_t tx_state_reg;

    wire addr_phase = hsel_in && htrans_in[1] && hready_in;

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign switch_m      = ctrl_reg[sabf_pkg::CTRL_SWITCH_BIT];
    assign snoop = other_target_in || ctrl_reg[sabf_pkg::CTRL_SNOOP_BIT];
    assign rd_status = addr_phase && !hwrite_in && haddr_in == sabf_pkg::STATUS_OFS;
    assign wr_cmd    = wr_pend_reg && wr_addr_reg == sabf_pkg::CMD_OFS;
    assign wr_tx     = wr_pend_reg && wr_addr_reg == sabf_pkg::TXREQ_OFS && hwdata_in[0];
    assign cmd       = sabf_pkg::sabf_cmd_t'(hwdata_in[10:0]);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite_in;
            wr_addr_reg <= haddr_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= sabf_pkg::CTRL_RESET;
        end else if (wr_pend_reg && wr_addr_reg == sabf_pkg::CTRL_OFS) begin
            ctrl_reg <= hwdata_in[2:0];
        end
    end

    // Status word: settings, watchdog reason, live levels
    always_comb begin
        status = 32'h0000_0000;
        status[NUM_SEG-1:0] = sel_reg;
        status[sabf_pkg::ST_LIVE_POS +: NUM_SEG] = seg_wire_in;
        status[sabf_pkg::ST_WD_BIT]    = wd_reason_reg;
        status[sabf_pkg::ST_SNOOP_BIT] = snoop;
        status[sabf_pkg::ST_BRAKE_BIT] = brake_reg;
        status[sabf_pkg::ST_ABORT_BIT] = abort_seen_reg;
        status[sabf_pkg::ST_RXERR_BIT] = rx_abort_reg;
        status[sabf_pkg::ST_RESP_BIT]  = respond_reg;
    end

    // Read data is captured in the address phase so the slave never waits
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_in) begin
            case (haddr_in)
                sabf_pkg::CTRL_OFS:   hrdata_out <= {29'h0000_0000, ctrl_reg};
                sabf_pkg::STATUS_OFS: hrdata_out <= status;
                default:              hrdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Command handling
    // ----------------------------------------
    wire cmd_target = wr_cmd && cmd.code == sabf_pkg::CMD_TARGET;
    wire cmd_select = wr_cmd && cmd.code == sabf_pkg::CMD_SELECT;
    // Snooping brake is optional, enabled by a control bit
    wire cmd_brake  = wr_cmd && cmd.code == sabf_pkg::CMD_BRAKE &&
                      (!snoop || ctrl_reg[sabf_pkg::CTRL_SNBRAKE_BIT]);
    wire [NUM_SEG-1:0] sel_def  = switch_m ? SEL_SW_DEF : SEL_MUX_DEF;
    wire [NUM_SEG-1:0] sel_new  = cmd.mask[NUM_SEG-1:0] | sel_def;
    logic [NUM_SEG-1:0] seg_prev_reg;
    logic [31:0]        wd_cnt_reg;
    wire wd_active  = |wd_chan_reg;
    wire wd_edge    = |((seg_wire_in ^ seg_prev_reg) & wd_chan_reg);
    wire wd_expire  = wd_active && !wd_edge && wd_cnt_reg == 32'(WD_LIMIT - 1);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            target_cmd_out <= 1'b0;
        end else begin
            target_cmd_out <= wr_cmd && cmd.code == sabf_pkg::CMD_OTHER && !snoop;
        end
    end

    // Channel selection; reset and target mode give the default set
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_reg <= SEL_MUX_DEF;
        end else if (cmd_target) begin
            sel_reg <= sel_def;
        end else if (cmd_select) begin
            sel_reg <= sel_new;
        end else if (wd_expire) begin
            sel_reg <= (sel_reg & ~wd_chan_reg) | sel_def;
        end else if (sel_reg == SEL_MUX_DEF && switch_m) begin
            sel_reg <= SEL_SW_DEF;
        end
    end

    // Brake level; no reply is ever produced so repeats are harmless
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            brake_reg     <= 1'b0;
            bcast_all_reg <= 1'b0;
        end else if (cmd_brake) begin
            brake_reg     <= cmd.mask[0];
            bcast_all_reg <= switch_m && cmd.mask[0];
        end else if (cmd_target || cmd_select || !switch_m) begin
            bcast_all_reg <= 1'b0;
        end
    end
    assign power_reduce_command_out = brake_reg;

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seg_prev_reg <= '1;
            wd_chan_reg  <= '0;
            wd_cnt_reg   <= 32'h0000_0000;
        end else begin
            seg_prev_reg <= seg_wire_in;
            if (cmd_select && |(sel_new & ~sel_reg & ~sel_def)) begin
                wd_chan_reg <= sel_new & ~sel_reg & ~sel_def;
                wd_cnt_reg  <= 32'h0000_0000;
            end else if (cmd_target || wd_edge || wd_expire) begin
                wd_chan_reg <= '0;
                wd_cnt_reg  <= 32'h0000_0000;
            end else if (wd_active) begin
                wd_cnt_reg  <= wd_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Reason is sticky until a status read; a new timeout wins over the clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wd_reason_reg <= 1'b0;
            rx_abort_reg  <= 1'b0;
        end else begin
            if (wd_expire) begin
                wd_reason_reg <= 1'b1;
            end else if (rd_status) begin
                wd_reason_reg <= 1'b0;
            end
            if (rx_parity_err_in && rx_frame_err_in) begin
                rx_abort_reg <= 1'b1;
            end else if (rd_status) begin
                rx_abort_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Transmit abort check
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_state_reg    <= sabf_pkg::TX_IDLE;
            frame_start_out <= 1'b0;
            abort_seen_reg  <= 1'b0;
            respond_reg     <= 1'b1;
        end else begin
            frame_start_out <= 1'b0;
            if (rd_status && !(tx_state_reg == sabf_pkg::TX_CHECK && !up_wire_in)) begin
                abort_seen_reg <= 1'b0;
            end
            case (tx_state_reg)
                sabf_pkg::TX_IDLE: begin
                    if (wr_tx && respond_reg) begin
                        tx_state_reg <= sabf_pkg::TX_CHECK;
                    end
                end
                sabf_pkg::TX_CHECK: begin
                    // Wire sampled just before start; low means initiator abort
                    if (!up_wire_in) begin
                        abort_seen_reg <= 1'b1;
                        respond_reg    <= 1'b0;
                        tx_state_reg   <= sabf_pkg::TX_HALT;
                    end else begin
                        frame_start_out <= 1'b1;
                        tx_state_reg    <= sabf_pkg::TX_IDLE;
                    end
                end
                sabf_pkg::TX_HALT: begin
                    if (cmd_target || cmd_select) begin
                        respond_reg  <= 1'b1;
                        tx_state_reg <= sabf_pkg::TX_IDLE;
                    end
                end
                default: tx_state_reg <= sabf_pkg::TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Wire relay
    // ----------------------------------------
    // Low levels are relayed one way per cycle; a segment we drive is not
    // echoed back upstream, which avoids a latch-up loop.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seg_wire_oe_out <= '0;
            up_wire_oe_out  <= 1'b0;
        end else begin
            seg_wire_oe_out <= (sel_reg | {NUM_SEG{bcast_all_reg}}) &
                               {NUM_SEG{!up_wire_in && !up_wire_oe_out}};
            up_wire_oe_out  <= |(sel_reg & ~seg_wire_in & ~seg_wire_oe_out);
        end
    end
    assign seg_wire_out = '0;
    assign up_wire_out  = 1'b0;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_abort_halts;
        @(posedge clk_in) disable iff (!rst_n_in)
        tx_state_reg == sabf_pkg::TX_CHECK && !up_wire_in |=> !frame_start_out && !respond_reg;
    endproperty
    a_abort_halts: assert property (p_abort_halts) else $error("start after abort");
    property p_start_fast;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_tx && respond_reg && tx_state_reg == sabf_pkg::TX_IDLE && up_wire_in ##1 up_wire_in
        |-> ##[1:24] frame_start_out;
    endproperty
    a_start_fast: assert property (p_start_fast) else $error("frame start too late");
    property p_switch_default;
        @(posedge clk_in) disable iff (!rst_n_in)
        switch_m && $past(switch_m) && $past(cmd_target) |-> sel_reg == SEL_SW_DEF;
    endproperty
    a_switch_default: assert property (p_switch_default) else $error("switch default");
    property p_mux_default;
        @(posedge clk_in) disable iff (!rst_n_in)
        !switch_m && $past(!switch_m) && $past(cmd_target) |-> sel_reg == SEL_MUX_DEF;
    endproperty
    a_mux_default: assert property (p_mux_default) else $error("bad mux default");
    property p_mux_no_bcast;
        @(posedge clk_in) disable iff (!rst_n_in)
        !switch_m ##1 !switch_m |-> !bcast_all_reg;
    endproperty
    a_mux_no_bcast: assert property (p_mux_no_bcast) else $error("mux broadcast");
    property p_snoop_ignore;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_cmd && snoop |=> !target_cmd_out;
    endproperty
    a_snoop_ignore: assert property (p_snoop_ignore) else $error("snoop acted on cmd");
    property p_wd_reopen;
        @(posedge clk_in) disable iff (!rst_n_in)
        wd_expire && !cmd_select && !cmd_target |=>
            (sel_reg & $past(wd_chan_reg)) == '0 && wd_reason_reg;
    endproperty
    a_wd_reopen: assert property (p_wd_reopen) else $error("watchdog did not reopen");
    property p_reason_sticky;
        @(posedge clk_in) disable iff (!rst_n_in)
        wd_reason_reg && !rd_status |=> wd_reason_reg;
    endproperty
    a_reason_sticky: assert property (p_reason_sticky) else $error("reason lost");
    property p_rx_abort;
        @(posedge clk_in) disable iff (!rst_n_in)
        rx_parity_err_in && rx_frame_err_in |=> rx_abort_reg;
    endproperty
    a_rx_abort: assert property (p_rx_abort) else $error("abort frame not flagged");
    c_abort: cover property (@(posedge clk_in) disable iff (!rst_n_in) abort_seen_reg);
    c_wd: cover property (@(posedge clk_in) disable iff (!rst_n_in) wd_expire);
    c_bcast: cover property (@(posedge clk_in) disable iff (!rst_n_in) bcast_all_reg);
endmodule : sabf_fanout

/* File: bench/sabf_wire_model.sv */
// Far-side model: initiator abort on the upstream wire and pulled-up segment wires
module sabf_wire_model #(
    parameter int NUM_SEG   = 8,
    parameter int ABORT_CYC = 1300,
    parameter int MARK_CYC  = 100
) (
    input  wire logic               clk_in,
    input  wire logic               up_oe_in,
    input  wire logic               abort_in,
    input  wire logic [NUM_SEG-1:0] seg_oe_in,
    input  wire logic [NUM_SEG-1:0] stuck_in,
    input  wire logic [NUM_SEG-1:0] toggle_in,
    output logic                    up_wire_out,
    output logic      [NUM_SEG-1:0] seg_wire_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Abort timing
    // ----------------------------------------
    int unsigned abort_cnt = 0;
    logic [3:0]  tick      = 4'h0;
    always_ff @(posedge clk_in) begin
        tick <= tick + 4'h1;
        // A new abort is refused until the high time after the last one has passed
        if (abort_in && abort_cnt == 0) begin
            abort_cnt <= ABORT_CYC + MARK_CYC;
        end else if (abort_cnt != 0) begin
            abort_cnt <= abort_cnt - 1;
        end
    end
    // Both wires idle high through pull-ups; any party may pull them low
    assign up_wire_out  = ~(up_oe_in | (abort_cnt > MARK_CYC));
    assign seg_wire_out = ~(seg_oe_in | stuck_in | (toggle_in & {NUM_SEG{tick[2]}}));
endmodule : sabf_wire_model

/* File: bench/tb.sv */
// Self-checking bench for the sideband fanout controller
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NS  = 8;
    localparam int WDL = 50;
    localparam int GAP = sabf_pkg::GAP_CYCLES;
    logic          clk_in   = 1'b0;
    logic          rst_n_in = 1'b0;
    logic          hsel = 1'b0, hwrite = 1'b0, perr = 1'b0, ferr = 1'b0;
    logic          other = 1'b0, abort = 1'b0;
    logic [7:0]    haddr  = 8'h00;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   hwdata = 32'h0, hrdata, rdat;
    logic          hready, hresp, up_w, up_oe, fstart, tcmd, brake;
    logic [NS-1:0] seg_w, seg_oe, stuck = '0, tog = '0;
    int            fails = 0, n_compared = 0, n_fs = 0, n_tc = 0;

    initial forever #20 clk_in = ~clk_in;

    sabf_fanout #(.NUM_SEG(NS), .WD_LIMIT(WDL)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .up_wire_in(up_w), .up_wire_out(), .up_wire_oe_out(up_oe), .other_target_in(other),
        .rx_parity_err_in(perr), .rx_frame_err_in(ferr), .frame_start_out(fstart),
        .target_cmd_out(tcmd), .power_reduce_command_out(brake), .seg_wire_in(seg_w),
        .seg_wire_out(), .seg_wire_oe_out(seg_oe));

    sabf_wire_model #(.NUM_SEG(NS)) far (
        .clk_in(clk_in), .up_oe_in(up_oe), .abort_in(abort), .seg_oe_in(seg_oe),
        .stuck_in(stuck), .toggle_in(tog), .up_wire_out(up_w), .seg_wire_out(seg_w));

    // One-cycle pulses are counted so a scenario can compare before and after
    always @(posedge clk_in) begin
        if (fstart === 1'b1) n_fs++;
        if (tcmd === 1'b1) n_tc++;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_in);
    endtask : ticks
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        // No wait limit of its own: only the bench watchdog ends a hung transfer
        do begin @(posedge clk_in); end while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk_in); end while (hready !== 1'b1);
        rdat = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : bus
    task automatic cmd(input sabf_pkg::sabf_cmd_code_t c, input logic [7:0] m);
        bus(1'b1, sabf_pkg::CMD_OFS, {21'h0, c, m});
    endtask : cmd
    task automatic status();
        bus(1'b0, sabf_pkg::STATUS_OFS, 32'h0);
    endtask : status
    task automatic abort_now();
        // Raised only between frames, so it falls where a start bit would
        abort <= 1'b1;
        @(posedge clk_in);
        abort <= 1'b0;
        ticks(5);
    endtask : abort_now
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        bus(1'b0, sabf_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", rdat, {29'h0, sabf_pkg::CTRL_RESET});
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", rdat, 32'h0);
    endtask : t_reset
    task automatic t_select();
        cmd(sabf_pkg::CMD_SELECT, 8'h0a);
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'h0a);
        ticks(WDL + 10);
        status();
        chk("reopen", {24'h0, rdat[7:0]}, 32'h0);
        chk("reason", {31'h0, rdat[sabf_pkg::ST_WD_BIT]}, 32'h1);
        status();
        chk("reason", {31'h0, rdat[sabf_pkg::ST_WD_BIT]}, 32'h0);
        tog <= 8'hff;
        cmd(sabf_pkg::CMD_SELECT, 8'hff);
        ticks(WDL + 10);
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'hff);
        cmd(sabf_pkg::CMD_TARGET, 8'h00);
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'h0);
        tog   <= '0;
        stuck <= 8'h30;
        ticks(3);
        status();
        chk("live", {24'h0, rdat[15:8]}, 32'hcf);
        cmd(sabf_pkg::CMD_SELECT, 8'h10);
        ticks(2);
        chk("relay", {31'h0, up_oe}, 32'h1);
        ticks(WDL + 10);
        chk("relay", {31'h0, up_oe}, 32'h0);
        status();
        chk("stuck reopen", {24'h0, rdat[7:0]}, 32'h0);
        stuck <= '0;
    endtask : t_select
    task automatic t_switch();
        bus(1'b1, sabf_pkg::CTRL_OFS, 32'h1);
        ticks(2);
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'h01);
        cmd(sabf_pkg::CMD_SELECT, 8'h04);
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'h05);
        cmd(sabf_pkg::CMD_TARGET, 8'h00);
        cmd(sabf_pkg::CMD_BRAKE, 8'h01);
        ticks(2);
        chk("brake", {31'h0, brake}, 32'h1);
        cmd(sabf_pkg::CMD_BRAKE, 8'h01);
        ticks(1);
        chk("brake repeat", {31'h0, brake}, 32'h1);
        abort_now();
        chk("bcast", {24'h0, seg_oe}, 32'hff);
        ticks(1500);
        cmd(sabf_pkg::CMD_BRAKE, 8'h00);
        ticks(1);
        chk("brake", {31'h0, brake}, 32'h0);
        bus(1'b1, sabf_pkg::CTRL_OFS, 32'h0);
        // Target mode again so the mux holds its empty default set
        cmd(sabf_pkg::CMD_TARGET, 8'h00);
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'h0);
        cmd(sabf_pkg::CMD_BRAKE, 8'h01);
        abort_now();
        chk("bcast", {24'h0, seg_oe}, 32'h0);
        ticks(1500);
        cmd(sabf_pkg::CMD_BRAKE, 8'h00);
        cmd(sabf_pkg::CMD_TARGET, 8'h00);
    endtask : t_switch
    task automatic t_tx();
        int n;
        n = n_fs;
        bus(1'b1, sabf_pkg::TXREQ_OFS, 32'h1);
        ticks(GAP);
        chk("frame", 32'(n_fs - n), 32'h1);
        abort_now();
        n = n_fs;
        bus(1'b1, sabf_pkg::TXREQ_OFS, 32'h1);
        ticks(GAP);
        chk("frame", 32'(n_fs - n), 32'h0);
        status();
        chk("abort", {31'h0, rdat[sabf_pkg::ST_ABORT_BIT]}, 32'h1);
        chk("resp", {31'h0, rdat[sabf_pkg::ST_RESP_BIT]}, 32'h0);
        ticks(1500);
        cmd(sabf_pkg::CMD_TARGET, 8'h00);
        n = n_fs;
        bus(1'b1, sabf_pkg::TXREQ_OFS, 32'h1);
        ticks(GAP);
        chk("frame", 32'(n_fs - n), 32'h1);
        perr <= 1'b1;
        ferr <= 1'b1;
        ticks(1);
        perr <= 1'b0;
        ferr <= 1'b0;
        ticks(2);
        status();
        chk("rxerr", {31'h0, rdat[sabf_pkg::ST_RXERR_BIT]}, 32'h1);
        perr <= 1'b1;
        ticks(1);
        perr <= 1'b0;
        ticks(2);
        status();
        chk("rxerr", {31'h0, rdat[sabf_pkg::ST_RXERR_BIT]}, 32'h0);
    endtask : t_tx
    task automatic t_snoop();
        int n;
        other <= 1'b1;
        ticks(2);
        status();
        chk("snoop", {31'h0, rdat[sabf_pkg::ST_SNOOP_BIT]}, 32'h1);
        n = n_tc;
        cmd(sabf_pkg::CMD_OTHER, 8'h00);
        ticks(3);
        chk("tcmd", 32'(n_tc - n), 32'h0);
        cmd(sabf_pkg::CMD_SELECT, 8'h02);
        status();
        chk("sel", {24'h0, rdat[7:0]}, 32'h02);
        cmd(sabf_pkg::CMD_BRAKE, 8'h01);
        ticks(2);
        chk("snoop brake", {31'h0, brake}, 32'h0);
        bus(1'b1, sabf_pkg::CTRL_OFS, 32'h4);
        cmd(sabf_pkg::CMD_BRAKE, 8'h01);
        ticks(2);
        chk("snoop brake", {31'h0, brake}, 32'h1);
        cmd(sabf_pkg::CMD_BRAKE, 8'h00);
        cmd(sabf_pkg::CMD_TARGET, 8'h00);
        other <= 1'b0;
        bus(1'b1, sabf_pkg::CTRL_OFS, 32'h2);
        status();
        chk("forced snoop", {31'h0, rdat[sabf_pkg::ST_SNOOP_BIT]}, 32'h1);
        bus(1'b1, sabf_pkg::CTRL_OFS, 32'h0);
        ticks(2);
        n = n_tc;
        cmd(sabf_pkg::CMD_OTHER, 8'h00);
        ticks(3);
        chk("tcmd", 32'(n_tc - n), 32'h1);
    endtask : t_snoop
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        ticks(20);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_select();
        t_switch();
        t_tx();
        t_snoop();
        report_and_stop();
    end
    // The scenarios need about 5000 cycles; a hang is cut off well past that
    initial begin
        ticks(20000);
        fails++;
        report_and_stop();
    end
endmodule : tb
